// *** tb/tpwm_checker.sv ***
// assertion checker for the timer pwm generator
`timescale 1ns/100ps
`default_nettype none
module tpwm_checker
  import tpwm_pkg::*;
#(parameter bit SEVEN_BIT_RESOLUTION_OPTION = 1'b0)
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [1:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] i_src_tick,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_pwm,
  input wire logic [1:0]  o_pin_sel
);
  logic [7:0] rq [4];
  logic [3:0] quiet;
  wire        on = rq[0][1] && quiet > 4'h8;
  wire        inv = rq[0][0];
  wire [7:0]  lo = SEVEN_BIT_RESOLUTION_OPTION ? TPWM_FULL_7 : TPWM_FULL_6;
  // shadow copy of what software wrote; count only trusted while stopped
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rq <= '{default: 8'h00};
      quiet <= 4'h0;
    end else begin
      if (i_wr) rq[i_addr] <= i_wdata;
      quiet <= i_wr ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_rd;
    i_rd && (i_addr != 2'h3 || rq[0][7:4] == 4'h0)
      |=> o_rdata == $past(rq[i_addr]);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read data");
  property p_sel;
    i_wr && i_addr == 2'h0 |-> ##2 o_pin_sel == $past(i_wdata[3:2], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("pin route wrong");
  property p_keep; quiet > 4'h2 |-> $stable(o_pin_sel); endproperty
  a_keep: assert property (p_keep) else $error("pin route moved");
  property p_full8; on && !rq[2][7] && rq[1] == 8'hFF |-> o_pwm == !inv;
  endproperty
  a_full8: assert property (p_full8) else $error("8-bit not full");
  property p_full6; on && rq[2][7] && rq[1] == lo |-> o_pwm == !inv;
  endproperty
  a_full6: assert property (p_full6) else $error("low res not full");
  property p_stop; rq[0][7:4] == 4'h0 && quiet > 4'h8 |-> $stable(o_pwm);
  endproperty
  a_stop: assert property (p_stop) else $error("moved when stopped");
  property p_min;
    $rose(o_pwm) && on && !inv && rq[1] == 8'h00 && rq[2][6:0] == 7'h00
      && i_src_tick[rq[0][7:4]] |=> !o_pwm;
  endproperty
  a_min: assert property (p_min) else $error("minimum pulse long");
endmodule
bind tpwm_top tpwm_checker #(
  .SEVEN_BIT_RESOLUTION_OPTION(SEVEN_BIT_RESOLUTION_OPTION)
) i_tpwm_checker (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_src_tick(i_src_tick),
  .o_rdata(o_rdata), .o_pwm(o_pwm), .o_pin_sel(o_pin_sel));
`default_nettype wire

// *** tb/tpwm_load.sv ***
// pin load model: measures high time and period of the pwm pin
`timescale 1ns/100ps
`default_nettype none
module tpwm_load (
  input  wire logic  i_clk,
  input  wire logic  i_pin,
  output logic [15:0] o_high,
  output logic [15:0] o_period
);
  logic [15:0] hi = 16'h0, per = 16'h0;
  logic        last = 1'b0;
  // figures hold the last whole period, from rise to rise
  always @(posedge i_clk) begin
    last <= i_pin;
    if (i_pin && !last) begin
      o_period <= per;
      o_high <= hi;
      per <= 16'h1;
      hi <= 16'h1;
    end else begin
      per <= per + 16'h1;
      hi <= hi + {15'h0, i_pin};
    end
  end
endmodule
`default_nettype wire

// *** tb/tpwm_top_tb.sv ***
// testbench for the timer pwm generator
`timescale 1ns/100ps
`default_nettype none
module tpwm_top_tb;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, o_pwm, o_pwm_7;
  logic src_half = 1'b0;
  logic [1:0] i_addr = 2'h0, o_pin_sel;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic [15:0] i_src_tick, ld_high, ld_period, ld7_high, ld7_period;
  // source 1 ticks every clock, source 5 every other, the rest stay idle
  assign i_src_tick = {10'h000, src_half, 3'h0, 1'b1, 1'b0};
  int mismatches = 0, checks_done = 0;
  localparam logic [7:0] RV [4] = '{8'h0C, 8'hA5, 8'h6B, 8'h5A};
  localparam logic [7:0] TC [10] = '{8'h1A, 8'h5A, 8'h1A, 8'h1A, 8'h1A,
    8'h1B, 8'h1A, 8'h1B, 8'h1A, 8'h18};
  localparam logic [7:0] TB [10] = '{8'h7F, 8'h09, 8'h1F, 8'h00, 8'h00,
    8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'h0F};
  localparam logic [7:0] TS [10] = '{8'h00, 8'h21, 8'h80, 8'h80, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  // period 0 marks full duty, where the high figure is the pin level
  localparam logic [15:0] TP [10] = '{16'h0100, 16'h1000, 16'h0040,
    16'h0040, 16'h0100, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0020};
  localparam logic [15:0] TH [10] = '{16'h0080, 16'h00A0, 16'h0020,
    16'h0001, 16'h0001, 16'h00C0, 16'h0001, 16'h0000, 16'h0001, 16'h0010};
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) src_half <= !src_half;
  tpwm_top i_tpwm_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_src_tick(i_src_tick),
    .o_rdata(o_rdata), .o_pwm(o_pwm), .o_pin_sel(o_pin_sel));
  tpwm_load i_tpwm_load (.i_clk(i_clk), .i_pin(o_pwm), .o_high(ld_high),
    .o_period(ld_period));
  // second timer built with the seven-bit low-resolution option
  tpwm_top #(.SEVEN_BIT_RESOLUTION_OPTION(1'b1)) i_tpwm_top_7 (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_src_tick(i_src_tick), .o_rdata(),
    .o_pwm(o_pwm_7), .o_pin_sel());
  tpwm_load i_tpwm_load_7 (.i_clk(i_clk), .i_pin(o_pwm_7),
    .o_high(ld7_high), .o_period(ld7_period));
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // strobe drops on the taking edge; an idle cycle keeps calls apart
  task wr(input logic [1:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, o_rdata});
    @(posedge i_clk);
  endtask
  task cfg(input logic [7:0] c, input logic [7:0] b, input logic [7:0] s);
    wr(2'h0, 8'h00);
    wr(2'h3, 8'h00);
    wr(2'h1, b);
    wr(2'h2, s);
    wr(2'h0, c);
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    results();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd(2'(k), 8'h00);
    for (int k = 0; k < 4; k++) wr(2'(k), RV[k]);
    for (int k = 0; k < 4; k++) rd(2'(k), RV[k]);
    chk("pin_sel", 16'h3, {14'h0, o_pin_sel});
    for (int k = 0; k < 10; k++) begin
      cfg(TC[k], TB[k], TS[k]);
      repeat (3 * (TP[k] < 16'h0080 ? 16'h0080 : TP[k]) + 9) @(posedge i_clk);
      #1;
      if (TP[k] == 16'h0) chk("level", TH[k], {15'h0, o_pwm});
      else begin
        chk("period", TP[k], ld_period);
        chk("high", TH[k], ld_high);
      end
      if (TS[k][7]) begin
        chk("period7", 16'h0080, ld7_period);
        chk("high7", {9'h000, TB[k][6:0]} + 16'h0001, ld7_high);
      end
      @(posedge i_clk);
    end
    results();
  end
endmodule
`default_nettype wire

// *** verilog/tpwm_counter.sv ***
// eight-bit up counter with software load
`timescale 1ns/100ps
`default_nettype none
module tpwm_counter
  import tpwm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_val,
  input  wire logic       i_wrap,
  output logic [7:0]      o_count
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= TPWM_RST_COUNT;
    end else if (i_load) begin
      o_count <= i_load_val;
    end else if (i_tick) begin
      o_count <= i_wrap ? 8'h00 : o_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verilog/tpwm_pkg.sv ***
// constants and types for the timer pwm generator
package tpwm_pkg;
  localparam logic [1:0] TPWM_OFS_CONTROL = 2'h0;
  localparam logic [1:0] TPWM_OFS_BOUND   = 2'h1;
  localparam logic [1:0] TPWM_OFS_SCALING = 2'h2;
  localparam logic [1:0] TPWM_OFS_COUNT   = 2'h3;
  localparam int TPWM_SRC_HI      = 7;
  localparam int TPWM_SRC_LO      = 4;
  localparam int TPWM_CTL_OUTSEL_HI = 3;
  localparam int TPWM_CTL_OUTSEL_LO = 2;
  localparam int TPWM_CTL_PWM     = 1;
  localparam int TPWM_CTL_INV     = 0;
  localparam int TPWM_SCL_RES     = 7;
  localparam int TPWM_PRE_HI      = 6;
  localparam int TPWM_PRE_LO      = 5;
  localparam int TPWM_DIV_HI      = 4;
  localparam int TPWM_DIV_LO      = 0;
  localparam logic [7:0] TPWM_RST_CONTROL = 8'h00;
  localparam logic [7:0] TPWM_RST_BOUND   = 8'h00;
  localparam logic [7:0] TPWM_RST_SCALING = 8'h00;
  localparam logic [7:0] TPWM_RST_COUNT   = 8'h00;
  localparam logic [7:0] TPWM_FULL_8      = 8'hFF;
  localparam logic [7:0] TPWM_FULL_7      = 8'h7F;
  localparam logic [7:0] TPWM_FULL_6      = 8'h3F;
  localparam logic [3:0] TPWM_SRC_STOP    = 4'h0;
  localparam logic [3:0] TPWM_SRC_CORE    = 4'h1;
  typedef enum logic [1:0] {
    TPWM_MODE_PERIOD,
    TPWM_MODE_PWM8,
    TPWM_MODE_PWM_LOW
  } tpwm_mode_t;
endpackage

// *** verilog/tpwm_prescaler.sv ***
// prescaler and scaler producing the scaled timer tick
`timescale 1ns/100ps
`default_nettype none
module tpwm_prescaler
  import tpwm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic [1:0] i_pre_sel,
  input  wire logic [4:0] i_div,
  output logic            o_tick
);
  logic [5:0] pre_cnt;
  logic [4:0] div_cnt;
  logic [5:0] pre_last;
  logic       pre_done;
  logic       div_done;

  assign pre_last = (i_pre_sel == 2'h0) ? 6'h00 :
                    (i_pre_sel == 2'h1) ? 6'h03 :
                    (i_pre_sel == 2'h2) ? 6'h0F : 6'h3F;
  assign pre_done = i_tick && (pre_cnt >= pre_last);
  assign div_done = pre_done && (div_cnt >= i_div);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_cnt <= 6'h00;
      div_cnt <= 5'h00;
      o_tick  <= 1'b0;
    end else begin
      o_tick <= div_done;
      if (i_tick) begin
        pre_cnt <= pre_done ? 6'h00 : pre_cnt + 6'h01;
      end
      if (pre_done) begin
        div_cnt <= div_done ? 5'h00 : div_cnt + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/tpwm_top.sv ***
// timer pwm generator: registers, clock select, pwm and period output
// Overview of operation
// - 8-bit pwm period is 256 scaled ticks.
// - 8-bit pwm output is high for bound plus one ticks.
// - control bits seven to four select the counting clock source.
// - scaling bits six to five divide by 1, 4, 16 or 64.
// - scaling bits four to zero further divide by value plus one.
// - software writes an eight-bit bound that sets pwm duty.
// - in pwm mode a bound at full scale holds output high always, or low always with the inversion bit set.
// - pwm with resolution bit set runs a 64 tick period.
// - 6-bit duty is bound plus one over 64.
// - build option makes low resolution 7-bit, period 128.
// - counter counts up and clears on reaching bound in period mode, at top of range in pwm mode.
// - software loads and reads the counter through the count register.
`timescale 1ns/100ps
`default_nettype none
module tpwm_top
  import tpwm_pkg::*;
#(
  parameter bit SEVEN_BIT_RESOLUTION_OPTION = 1'b0
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [15:0] i_src_tick,
  output logic [7:0]      o_rdata,
  output logic            o_pwm,
  output logic [1:0]      o_pin_sel
);
  logic [7:0] timer_control;
  logic [7:0] timer_bound;
  logic [7:0] timer_scaling;
  logic [7:0] timer_count_value;
  logic       period_phase;
  logic       pwm_out;
  logic       next_pwm;

  wire        wr_control = i_wr && (i_addr == TPWM_OFS_CONTROL);
  wire        wr_bound   = i_wr && (i_addr == TPWM_OFS_BOUND);
  wire        wr_scaling = i_wr && (i_addr == TPWM_OFS_SCALING);
  wire        wr_count   = i_wr && (i_addr == TPWM_OFS_COUNT);

  // source 0 means stopped; otherwise one enable line per source
  wire [3:0]  src_sel = timer_control[TPWM_SRC_HI:TPWM_SRC_LO];
  wire        src_tick = (src_sel == TPWM_SRC_STOP) ? 1'b0 :
                         i_src_tick[src_sel];
  wire        scaled_tick;

  wire        pwm_mode = timer_control[TPWM_CTL_PWM];
  wire        low_res  = timer_scaling[TPWM_SCL_RES];
  wire [7:0]  full_mask = !low_res ? TPWM_FULL_8 :
                          (SEVEN_BIT_RESOLUTION_OPTION ? TPWM_FULL_7
                                                       : TPWM_FULL_6);
  wire        is_top_of_range = (timer_count_value & full_mask) == full_mask;
  wire        hit_bound = timer_count_value == timer_bound;
  wire        wrap = pwm_mode ? is_top_of_range : hit_bound;
  wire [7:0]  count_in_range = timer_count_value & full_mask;
  wire [7:0]  bound_in_range = timer_bound & full_mask;
  // full-scale bound compares at or above every count: always high
  wire        pwm_level = count_in_range <= bound_in_range;

  always_comb begin
    next_pwm = pwm_out;
    if (pwm_mode) begin
      next_pwm = pwm_level;
    end else if (scaled_tick && hit_bound) begin
      next_pwm = !period_phase;
    end
  end

  tpwm_prescaler u_prescaler (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_tick    (src_tick),
    .i_pre_sel (timer_scaling[TPWM_PRE_HI:TPWM_PRE_LO]),
    .i_div     (timer_scaling[TPWM_DIV_HI:TPWM_DIV_LO]),
    .o_tick    (scaled_tick)
  );

  tpwm_counter u_counter (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_tick     (scaled_tick),
    .i_load     (wr_count),
    .i_load_val (i_wdata),
    .i_wrap     (wrap),
    .o_count    (timer_count_value)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer_control <= TPWM_RST_CONTROL;
      timer_bound   <= TPWM_RST_BOUND;
      timer_scaling <= TPWM_RST_SCALING;
    end else begin
      if (wr_control) begin
        timer_control <= i_wdata;
      end
      if (wr_bound) begin
        timer_bound <= i_wdata;
      end
      if (wr_scaling) begin
        timer_scaling <= i_wdata;
      end
    end
  end

  // period mode toggles at each bound match for a 50 percent wave
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      period_phase <= 1'b0;
      pwm_out      <= 1'b0;
    end else begin
      pwm_out <= next_pwm;
      if (!pwm_mode) begin
        period_phase <= next_pwm;
      end else begin
        period_phase <= 1'b0;
      end
    end
  end

  // inversion lets a second timer act as the complementary half
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pwm     <= 1'b0;
      o_pin_sel <= 2'h0;
    end else begin
      o_pwm     <= pwm_out ^ timer_control[TPWM_CTL_INV];
      o_pin_sel <= timer_control[TPWM_CTL_OUTSEL_HI:TPWM_CTL_OUTSEL_LO];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        TPWM_OFS_CONTROL: o_rdata <= timer_control;
        TPWM_OFS_BOUND:   o_rdata <= timer_bound;
        TPWM_OFS_SCALING: o_rdata <= timer_scaling;
        TPWM_OFS_COUNT:   o_rdata <= timer_count_value;
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire
